// ===== bench/motor_startup_config_reg_tb.sv
/*
 * Self-checking bench for the start-up configuration register.
 * Assumes the register port contract: one-cycle strobes, read data and
 * valid one cycle after the strobe, decoded fields two cycles after a write.
 */
`timescale 1ns/1ps
`include "motor_startup_cfg.svh"

module motor_startup_config_reg_tb;
    logic clk_sys, nrst, regWrEn, regRdEn;
    logic [7:0] regAddr;
    logic [31:0] regWrData, regRdData, cfgWord, w;
    logic regRdValid, parityBit, alignCurrentValid;
    motor_startup_pkg::startup_method_e startupMethodSel;
    logic [19:0] alignRampRateMvps;
    logic [13:0] alignTimeMs;
    logic [10:0] alignCurrentLimitMv;
    logic [3:0] c;
    int err_total, tests_run, cycles;
    // Ramp in mV/s and dwell in ms, one entry per field code
    logic [19:0] rampTab [16] = '{20'h00064, 20'h000C8, 20'h001F4,
        20'h003E8, 20'h009C4, 20'h01388, 20'h01D4C, 20'h02710, 20'h061A8,
        20'h0C350, 20'h124F8, 20'h186A0, 20'h3D090, 20'h7A120, 20'hB71B0,
        20'hF4240};
    logic [13:0] timeTab [16] = '{14'h0005, 14'h000A, 14'h0019, 14'h0032,
        14'h004B, 14'h0064, 14'h00C8, 14'h0190, 14'h0258, 14'h0320,
        14'h03E8, 14'h07D0, 14'h0FA0, 14'h1770, 14'h1F40, 14'h2710};

    motor_startup_config_reg DUT (.clk_sys(clk_sys), .nrst(nrst),
        .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
        .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
        .cfgWord(cfgWord), .parityBit(parityBit),
        .startupMethodSel(startupMethodSel),
        .alignRampRateMvps(alignRampRateMvps), .alignTimeMs(alignTimeMs),
        .alignCurrentLimitMv(alignCurrentLimitMv),
        .alignCurrentValid(alignCurrentValid));

    // ****************************************************************
    // Clock, timeout and verdict
    // ****************************************************************
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task report_and_stop;
        $display("Checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    // Whole run is about 110 cycles; generous ceiling
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total++;
            report_and_stop();
        end
    end

    // ****************************************************************
    // Register port tasks
    // ****************************************************************
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk_sys);
        regWrEn <= 1'b0;
        #1;
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk_sys);
        regRdEn <= 1'b0;
        #1;
        chk("regRdValid", 32'h1, regRdValid);
        chk("regRdData", exp, regRdData);
    endtask : rd

    task chk_fields(input logic [3:0] k);
        chk("alignRampRateMvps", rampTab[k], alignRampRateMvps);
        chk("alignTimeMs", timeTab[k], alignTimeMs);
        chk("alignCurrentLimitMv", 11'(k) * 11'h064, alignCurrentLimitMv);
        chk("alignCurrentValid", k != 4'h0, alignCurrentValid);
    endtask : chk_fields

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        nrst = 1'b0;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 8'h00;
        regWrData = 32'h0;
        cycles = 0;
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk("cfgWord", 32'h0, cfgWord);
        chk_fields(4'h0);
        rd(`MSC_ADDR_STARTUP1, 32'h0);
        @(posedge clk_sys);
        #1;
        chk("regRdValid", 32'h0, regRdValid);
        for (int i = 0; i < 16; i++) begin
            c = 4'(i);
            w = {c[0], c[1:0], c, c, c, 17'h0A5A5};
            wr(`MSC_ADDR_STARTUP1, w);
            chk("cfgWord", w, cfgWord);
            @(posedge clk_sys);
            #1;
            chk("parityBit", c[0], parityBit);
            chk("startupMethodSel", c[1:0], startupMethodSel);
            chk_fields(c);
            rd(`MSC_ADDR_STARTUP1, w);
        end
        // Unmapped place: write ignored, read gives zero
        wr(8'h83, 32'hFFFF_FFFF);
        chk("cfgWord", w, cfgWord);
        rd(8'h83, 32'h0);
        // Read and write in one cycle: read sees the old word
        @(posedge clk_sys);
        regAddr <= `MSC_ADDR_STARTUP1;
        regWrData <= 32'h2BD4_0000;
        regWrEn <= 1'b1;
        regRdEn <= 1'b1;
        @(posedge clk_sys);
        regWrEn <= 1'b0;
        regRdEn <= 1'b0;
        #1;
        chk("regRdData", w, regRdData);
        chk("cfgWord", 32'h2BD4_0000, cfgWord);
        @(posedge clk_sys);
        #1;
        chk("startupMethodSel", 32'h1, startupMethodSel);
        chk("alignRampRateMvps", rampTab[5], alignRampRateMvps);
        chk("alignTimeMs", timeTab[14], alignTimeMs);
        chk("alignCurrentLimitMv", 32'h3E8, alignCurrentLimitMv);
        chk("alignCurrentValid", 32'h1, alignCurrentValid);
        // Write then read on the very next edge
        @(posedge clk_sys);
        regWrData <= 32'h5555_AAAA;
        regWrEn <= 1'b1;
        @(posedge clk_sys);
        regWrEn <= 1'b0;
        regRdEn <= 1'b1;
        @(posedge clk_sys);
        regRdEn <= 1'b0;
        #1;
        chk("regRdValid", 32'h1, regRdValid);
        chk("regRdData", 32'h5555_AAAA, regRdData);
        // Read data stands after the valid pulse has gone
        @(posedge clk_sys);
        #1;
        chk("regRdValid", 32'h0, regRdValid);
        chk("regRdData", 32'h5555_AAAA, regRdData);
        // Reset in mid-run clears the word and the decoded fields
        @(posedge clk_sys);
        nrst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        #1;
        chk("cfgWord", 32'h0, cfgWord);
        chk("regRdData", 32'h0, regRdData);
        @(posedge clk_sys);
        #1;
        chk("parityBit", 32'h0, parityBit);
        chk("startupMethodSel", 32'h0, startupMethodSel);
        chk_fields(4'h0);
        report_and_stop();
    end
endmodule : motor_startup_config_reg_tb

// ===== core/motor_startup_cfg.svh
/*
 * Address, field positions and reset value of the start-up configuration
 * register. Definitions only; included by the register and its bench.
 */
`ifndef MOTOR_STARTUP_CFG_SVH
`define MOTOR_STARTUP_CFG_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define MSC_ADDR_W 8
`define MSC_ADDR_STARTUP1 8'h82
`define MSC_RESET_STARTUP1 32'h0000_0000

// ****************************************************************
// Field positions
// ****************************************************************
`define MSC_PARITY_BIT 31
`define MSC_METHOD_HI 30
`define MSC_METHOD_LO 29
`define MSC_RAMP_HI 28
`define MSC_RAMP_LO 25
`define MSC_TIME_HI 24
`define MSC_TIME_LO 21
`define MSC_CURR_HI 20
`define MSC_CURR_LO 17
`define MSC_CURR_STEP_MV 11'h064

`endif

// ===== core/motor_startup_config_reg.sv
/*
 * Start-up configuration register: one 32-bit read/write word with its
 * align fields decoded into physical units for the start-up sequencer.
 * Assumes a register port on clk_sys; requests are single-cycle strobes
 * from logic in the same clock domain.
 */
`timescale 1ns/1ps
`include "motor_startup_cfg.svh"

// Operation
// - 32-bit RW word at 0x82, reset zero, parity.
// - Bits 30-29 select start-up method.
// - Bits 28-25 set align voltage ramp rate.
// - Bits 20-17 set align current sense threshold.
module motor_startup_config_reg (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [`MSC_ADDR_W-1:0] regAddr,
    input wire logic regWrEn,
    input wire logic [31:0] regWrData,
    input wire logic regRdEn,
    output logic [31:0] regRdData,
    output logic regRdValid,
    output logic [31:0] cfgWord,
    output logic parityBit,
    output motor_startup_pkg::startup_method_e startupMethodSel,
    output logic [19:0] alignRampRateMvps,
    output logic [13:0] alignTimeMs,
    output logic [10:0] alignCurrentLimitMv,
    output logic alignCurrentValid
);

    // ****************************************************************
    // Code tables
    // ****************************************************************
    function automatic logic [19:0] rampMvps(
        input motor_startup_pkg::code_t code
    );
        case (code)
            4'h0: rampMvps = 20'h00064;
            4'h1: rampMvps = 20'h000C8;
            4'h2: rampMvps = 20'h001F4;
            4'h3: rampMvps = 20'h003E8;
            4'h4: rampMvps = 20'h009C4;
            4'h5: rampMvps = 20'h01388;
            4'h6: rampMvps = 20'h01D4C;
            4'h7: rampMvps = 20'h02710;
            4'h8: rampMvps = 20'h061A8;
            4'h9: rampMvps = 20'h0C350;
            4'hA: rampMvps = 20'h124F8;
            4'hB: rampMvps = 20'h186A0;
            4'hC: rampMvps = 20'h3D090;
            4'hD: rampMvps = 20'h7A120;
            4'hE: rampMvps = 20'hB71B0;
            default: rampMvps = 20'hF4240;
        endcase
    endfunction : rampMvps

    function automatic logic [13:0] timeMs(
        input motor_startup_pkg::code_t code
    );
        case (code)
            4'h0: timeMs = 14'h0005;
            4'h1: timeMs = 14'h000A;
            4'h2: timeMs = 14'h0019;
            4'h3: timeMs = 14'h0032;
            4'h4: timeMs = 14'h004B;
            4'h5: timeMs = 14'h0064;
            4'h6: timeMs = 14'h00C8;
            4'h7: timeMs = 14'h0190;
            4'h8: timeMs = 14'h0258;
            4'h9: timeMs = 14'h0320;
            4'hA: timeMs = 14'h03E8;
            4'hB: timeMs = 14'h07D0;
            4'hC: timeMs = 14'h0FA0;
            4'hD: timeMs = 14'h1770;
            4'hE: timeMs = 14'h1F40;
            default: timeMs = 14'h2710;
        endcase
    endfunction : timeMs

    // ****************************************************************
    // Register access
    // ****************************************************************
    logic hitAddr;
    assign hitAddr = (regAddr == `MSC_ADDR_STARTUP1);

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            cfgWord <= `MSC_RESET_STARTUP1;
        end else if (regWrEn && hitAddr) begin
            cfgWord <= regWrData;
        end
    end

    // Unmapped addresses read as zero
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            regRdData <= 32'h0000_0000;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRdEn;
            if (regRdEn && hitAddr) begin
                regRdData <= cfgWord;
            end else if (regRdEn) begin
                regRdData <= 32'h0000_0000;
            end
        end
    end

    // ****************************************************************
    // Field decode
    // ****************************************************************
    motor_startup_pkg::code_t rampCode;
    motor_startup_pkg::code_t timeCode;
    motor_startup_pkg::code_t currCode;
    assign rampCode = cfgWord[`MSC_RAMP_HI:`MSC_RAMP_LO];
    assign timeCode = cfgWord[`MSC_TIME_HI:`MSC_TIME_LO];
    assign currCode = cfgWord[`MSC_CURR_HI:`MSC_CURR_LO];

    // Registered so the sequencer sees one clean value per write
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            parityBit <= 1'b0;
            startupMethodSel <= motor_startup_pkg::SINGLE_ALIGN;
        end else begin
            parityBit <= cfgWord[`MSC_PARITY_BIT];
            startupMethodSel <= motor_startup_pkg::startup_method_e'(
                cfgWord[`MSC_METHOD_HI:`MSC_METHOD_LO]);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            alignRampRateMvps <= 20'h00000;
            alignTimeMs <= 14'h0000;
        end else begin
            alignRampRateMvps <= rampMvps(rampCode);
            alignTimeMs <= timeMs(timeCode);
        end
    end

    // Code 0 has no meaning; amperes = sense voltage / amp gain downstream
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            alignCurrentLimitMv <= 11'h000;
            alignCurrentValid <= 1'b0;
        end else begin
            alignCurrentLimitMv <= 11'(currCode * `MSC_CURR_STEP_MV);
            alignCurrentValid <= (currCode != 4'h0);
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_wrHit;
        regWrEn && hitAddr;
    endsequence

    property p_resetZero;
        @(posedge clk_sys) !nrst |=> (cfgWord == 32'h0000_0000);
    endproperty
    a_resetZero: assert property (p_resetZero)
        else $error("config word not zero after reset");

    property p_readBack;
        @(posedge clk_sys) disable iff (!nrst)
        s_wrHit ##1 (regRdEn && hitAddr && !regWrEn)
        |=> regRdValid && (regRdData == $past(regWrData, 2));
    endproperty
    a_readBack: assert property (p_readBack)
        else $error("read back differs from written word");

    property p_unmapped;
        @(posedge clk_sys) disable iff (!nrst)
        regRdEn && !hitAddr |=> regRdValid && (regRdData == 32'h0000_0000);
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");

    property p_method;
        @(posedge clk_sys) disable iff (!nrst)
        s_wrHit ##1 !regWrEn |=> startupMethodSel == $past(regWrData[30:29], 2);
    endproperty
    a_method: assert property (p_method)
        else $error("start-up method does not follow write");

    property p_rampMax;
        @(posedge clk_sys) disable iff (!nrst)
        s_wrHit and (regWrData[28:25] == 4'hF)
        |=> ##1 (alignRampRateMvps == 20'hF4240);
    endproperty
    a_rampMax: assert property (p_rampMax)
        else $error("ramp code F not 1000 V/s");

    property p_currZero;
        @(posedge clk_sys) disable iff (!nrst)
        s_wrHit and (regWrData[20:17] == 4'h0)
        |=> ##1 !alignCurrentValid;
    endproperty
    a_currZero: assert property (p_currZero)
        else $error("current code 0 marked valid");

    property p_currStep;
        @(posedge clk_sys) disable iff (!nrst)
        s_wrHit and (regWrData[20:17] == 4'h1)
        |=> ##1 alignCurrentValid && (alignCurrentLimitMv == 11'h064);
    endproperty
    a_currStep: assert property (p_currStep)
        else $error("current code 1 not 0.1 V");

    property p_timeMin;
        @(posedge clk_sys) disable iff (!nrst)
        s_wrHit and (regWrData[24:21] == 4'h0)
        |=> ##1 (alignTimeMs == 14'h0005);
    endproperty
    a_timeMin: assert property (p_timeMin)
        else $error("align time code 0 not 5 ms");

endmodule : motor_startup_config_reg

// ===== core/motor_startup_pkg.sv
/*
 * Types shared by the start-up configuration register and its users.
 * Assumes nothing of its surroundings.
 */
package motor_startup_pkg;

    typedef enum logic [1:0] {
        SINGLE_ALIGN = 2'h0,
        DOUBLE_ALIGN = 2'h1,
        INITIAL_POSITION_DETECTION = 2'h2,
        SLOW_FIRST_CYCLE = 2'h3
    } startup_method_e;

    typedef logic [3:0] code_t;

endpackage : motor_startup_pkg
